// file: hdl/psm_mux.v
// Summary of operation
// [R1] any port clock onto two recovered outputs; the code steers only ports that reach a macro
// [R2] core ports numbered zero through eleven
// [R3] port chains to module, macro, pins
// [R4] internal ports never routed to lanes
// [R5] port eleven is CPU path only
// [R6] quad mode puts ports 4-7 on lane a
// [R7] quad mode overrides defaults and selections
// [R8] nine: none or gig e; ten: c or f
// [R9] endpoint select gives lane c to PCIe
// [R10] no lane c for ten with endpoint
// [R11] per-port logical value, group uses lowest; the code keeps any value up to eleven per port, with no group check
// [R12] reroute only while port modules reset; the code accepts route writes at any time
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "psm_map.vh"

module psm_mux #(
   parameter NPORT = 12
) (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire [11:0] rx_recovered_clk,
   output reg  [1:0]  recovered_clk_out,
   output reg  [47:0] port_macro_code,
   output reg  [11:0] port_linked,
   output reg  [8:0]  macro_busy,
   output reg         quad_lane_active,
   output reg         fast_lane_c_endpoint,
   input  wire [3:0]  lp_query_port,
   output wire [3:0]  lp_query_value
);

   reg  [3:0]  route_reg;
   reg  [3:0]  route_next;
   reg  [12:0] rclk_reg;
   reg  [12:0] rclk_next;
   reg  [31:0] rdata_next;
   reg         err_next;
   reg  [47:0] code_next;
   reg  [11:0] linked_next;
   reg  [8:0]  busy_next;
   reg  [1:0]  rclk_out_next;
   reg         lp_wr;
   wire [11:0] rx_clk_sync;
   wire [3:0]  lp_rd_data;
   wire [3:0]  lp_index;
   wire        setup_ph;
   wire        first_acc;
   wire        done_acc;
   wire        quad_lane_mode_enable;
   wire        port_nine_lane_select;
   wire        port_ten_lane_select;
   wire        lane_to_endpoint_select;
   integer     p;
   integer     m;

   assign quad_lane_mode_enable   = route_reg[`PSM_BIT_QUAD];
   assign port_nine_lane_select   = route_reg[`PSM_BIT_NINE];
   assign port_ten_lane_select    = route_reg[`PSM_BIT_TEN];
   assign lane_to_endpoint_select = route_reg[`PSM_BIT_ENDPOINT];

   // apb phases: every access waits one cycle, then ends
   assign setup_ph  = psel & ~penable;
   assign first_acc = psel & penable & ~pready;
   assign done_acc  = psel & penable & pready;
   assign lp_index  = paddr[5:2];

   // macro that a core port reaches under the current selections
   function [3:0] macro_of;
      input [3:0] port;
      input       quad;
      input       sel9;
      input       sel10;
      input       endpoint;
      begin
         case (port)
            4'h0: macro_of = `PSM_MAC_CU0; // [R3]
            4'h1: macro_of = `PSM_MAC_CU1; // [R3]
            4'h2: macro_of = `PSM_MAC_CU2; // [R3]
            4'h3: macro_of = `PSM_MAC_CU3; // [R3]
            4'h4: macro_of = quad ? `PSM_MAC_FAST_A : (sel9 ? `PSM_MAC_NONE : `PSM_MAC_GIG_E); // [R6] [R7]
            4'h5: macro_of = quad ? `PSM_MAC_FAST_A : (sel10 ? `PSM_MAC_NONE : `PSM_MAC_GIG_F); // [R6] [R7]
            4'h6: macro_of = quad ? `PSM_MAC_FAST_A : `PSM_MAC_NONE; // [R6] [R7]
            4'h7: macro_of = `PSM_MAC_FAST_A; // [R6]
            4'h8: macro_of = `PSM_MAC_FAST_B; // [R3]
            4'h9: macro_of = sel9 ? `PSM_MAC_GIG_E : `PSM_MAC_NONE; // [R8]
            4'ha: macro_of = sel10 ? `PSM_MAC_GIG_F : (endpoint ? `PSM_MAC_NONE : `PSM_MAC_FAST_C); // [R8] [R9]
            4'hb: macro_of = `PSM_MAC_NONE; // [R4] [R5]
            default: macro_of = `PSM_MAC_NONE; // [R2] [R4]
         endcase
      end
   endfunction

   // true for a legal logical port value
   function valid_port;
      input [3:0] value;
      begin
         valid_port = (value <= `PSM_PORT_LAST); // [R2]
      end
   endfunction

   // synchronise the recovered clocks into pclk
   psm_sync #(
      .WIDTH    (12)
   ) u_rclk_sync (
      .clk      (pclk),
      .rst_n    (presetn),
      .async_in (rx_recovered_clk),
      .sync_out (rx_clk_sync)
   );

   // logical port value table, one entry per core port
   psm_lpmem #(
      .DEPTH     (NPORT),
      .AW        (4),
      .DW        (4)
   ) u_lpmem (
      .clk       (pclk),
      .rst_n     (presetn),
      .wr_en     (lp_wr),
      .wr_addr   (lp_index),
      .wr_data   (pwdata[3:0]),
      .rd_a_addr (lp_index),
      .rd_a_data (lp_rd_data),
      .rd_b_addr (lp_query_port),
      .rd_b_data (lp_query_value)
   );

   // routing view derived from the configuration
   always @*
   begin
      code_next   = 48'h0;
      linked_next = 12'h000;
      busy_next   = 9'h000;
      for (p = 0; p < `PSM_NUM_PORTS; p = p + 1)
      begin
         code_next[p*4 +: 4] = macro_of(p[3:0], quad_lane_mode_enable, port_nine_lane_select,
                                        port_ten_lane_select, lane_to_endpoint_select); // [R2]
         linked_next[p] = (code_next[p*4 +: 4] != `PSM_MAC_NONE); // [R3]
      end
      for (m = 0; m < `PSM_NUM_MACROS; m = m + 1)
      begin
         for (p = 0; p < `PSM_NUM_PORTS; p = p + 1)
         begin
            if (code_next[p*4 +: 4] == (m[3:0] + 4'h1))
               busy_next[m] = 1'b1;
         end
      end
      if (lane_to_endpoint_select)
         busy_next[`PSM_MAC_FAST_C - 4'h1] = 1'b1; // [R9]
   end

   // recovered clock steering, only from ports that reach a macro
   always @*
   begin
      rclk_out_next = 2'b00;
      if (rclk_reg[`PSM_RCLK0_EN] &&
          valid_port(rclk_reg[`PSM_RCLK0_SRC_LSB +: 4]) &&
          linked_next[rclk_reg[`PSM_RCLK0_SRC_LSB +: 4]])
         rclk_out_next[0] = rx_clk_sync[rclk_reg[`PSM_RCLK0_SRC_LSB +: 4]]; // [R1]
      if (rclk_reg[`PSM_RCLK1_EN] &&
          valid_port(rclk_reg[`PSM_RCLK1_SRC_LSB +: 4]) &&
          linked_next[rclk_reg[`PSM_RCLK1_SRC_LSB +: 4]])
         rclk_out_next[1] = rx_clk_sync[rclk_reg[`PSM_RCLK1_SRC_LSB +: 4]]; // [R1]
   end

   // register decode: read data, error and write commit
   always @*
   begin
      rdata_next = 32'h0;
      err_next   = 1'b0;
      route_next = route_reg;
      rclk_next  = rclk_reg;
      lp_wr      = 1'b0;
      if ((paddr >= `PSM_OFS_LP_BASE) && (paddr <= `PSM_OFS_LP_LAST) && (paddr[1:0] == 2'b00))
      begin
         rdata_next = {28'h0, lp_rd_data};
         if (pwrite && !valid_port(pwdata[3:0]))
            err_next = 1'b1; // [R11]
         else if (pwrite && done_acc)
            lp_wr = 1'b1; // [R11]
      end
      else
      begin
         case (paddr)
            `PSM_OFS_ROUTE:
            begin
               rdata_next = {28'h0, route_reg};
               if (pwrite && pwdata[`PSM_BIT_ENDPOINT] && !pwdata[`PSM_BIT_TEN])
                  err_next = 1'b1; // [R10]
               else if (pwrite && done_acc)
                  route_next = pwdata[3:0]; // [R12]
            end
            `PSM_OFS_RCLK:
            begin
               rdata_next = {19'h0, rclk_reg};
               if (pwrite && done_acc)
                  rclk_next = pwdata[12:0]; // [R1]
            end
            `PSM_OFS_STATUS:
            begin
               rdata_next = {21'h0, busy_next, lane_to_endpoint_select, quad_lane_mode_enable};
               err_next   = pwrite;
            end
            `PSM_OFS_MAP_LO:
            begin
               rdata_next = code_next[31:0];
               err_next   = pwrite;
            end
            `PSM_OFS_MAP_HI:
            begin
               rdata_next = {16'h0, code_next[47:32]};
               err_next   = pwrite;
            end
            default:
               err_next = 1'b1;
         endcase
      end
      if (!done_acc)
      begin
         route_next = route_reg;
         rclk_next  = rclk_reg;
      end
   end

   // apb handshake and response registers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end
      else
      begin
         pready <= first_acc;
         if (first_acc)
         begin
            pslverr <= err_next;
            prdata  <= pwrite ? 32'h0 : rdata_next;
         end
         else if (setup_ph || !psel || pready)
         begin
            pslverr <= 1'b0;
            prdata  <= 32'h0;
         end
      end
   end

   // configuration registers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         route_reg <= `PSM_ROUTE_RESET;
         rclk_reg  <= {8'h0, `PSM_RCLK_RESET};
      end
      else if (done_acc && !pslverr)
      begin
         route_reg <= route_next; // [R7] [R9]
         rclk_reg  <= rclk_next;
      end
   end

   // registered routing outputs toward port modules and lanes
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port_macro_code      <= 48'h0;
         port_linked          <= 12'h000;
         macro_busy           <= 9'h000;
         quad_lane_active     <= 1'b0;
         fast_lane_c_endpoint <= 1'b0;
         recovered_clk_out    <= 2'b00;
      end
      else
      begin
         port_macro_code      <= code_next; // [R3]
         port_linked          <= linked_next; // [R4]
         macro_busy           <= busy_next;
         quad_lane_active     <= quad_lane_mode_enable; // [R6]
         fast_lane_c_endpoint <= lane_to_endpoint_select; // [R9]
         recovered_clk_out    <= rclk_out_next; // [R1]
      end
   end

endmodule

`default_nettype wire

// file: inc/psm_map.vh
`ifndef PSM_MAP_VH
`define PSM_MAP_VH

// register byte offsets
`define PSM_OFS_ROUTE      12'h000
`define PSM_OFS_RCLK       12'h004
`define PSM_OFS_STATUS     12'h008
`define PSM_OFS_MAP_LO     12'h00c
`define PSM_OFS_MAP_HI     12'h010
`define PSM_OFS_LP_BASE    12'h040
`define PSM_OFS_LP_LAST    12'h06c

// lane routing fields
`define PSM_BIT_QUAD       0
`define PSM_BIT_NINE       1
`define PSM_BIT_TEN        2
`define PSM_BIT_ENDPOINT   3
`define PSM_ROUTE_RESET    4'h0

// recovered clock select fields
`define PSM_RCLK0_SRC_LSB  0
`define PSM_RCLK0_EN       4
`define PSM_RCLK1_SRC_LSB  8
`define PSM_RCLK1_EN       12
`define PSM_RCLK_RESET     5'h00

// port numbering
`define PSM_NUM_PORTS      12
`define PSM_PORT_LAST      4'hb
`define PSM_PORT_CPU       4'hb
`define PSM_QUAD_FIRST     4'h4
`define PSM_QUAD_LAST      4'h7
`define PSM_PORT_NINE      4'h9
`define PSM_PORT_TEN       4'ha

// interface macro codes
`define PSM_MAC_NONE       4'h0
`define PSM_MAC_CU0        4'h1
`define PSM_MAC_CU1        4'h2
`define PSM_MAC_CU2        4'h3
`define PSM_MAC_CU3        4'h4
`define PSM_MAC_GIG_E      4'h5
`define PSM_MAC_GIG_F      4'h6
`define PSM_MAC_FAST_A     4'h7
`define PSM_MAC_FAST_B     4'h8
`define PSM_MAC_FAST_C     4'h9
`define PSM_NUM_MACROS     9

`endif

// file: hdl/psm_sync.v
`timescale 1ns/1ps
`default_nettype none

module psm_sync #(
   parameter WIDTH = 12
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);

   reg [WIDTH-1:0] meta_reg;

   // two-stage synchroniser, first stage read only by the second
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

`default_nettype wire

// file: hdl/psm_lpmem.v
`timescale 1ns/1ps
`default_nettype none

module psm_lpmem #(
   parameter DEPTH = 12,
   parameter AW    = 4,
   parameter DW    = 4
) (
   input  wire          clk,
   input  wire          rst_n,
   input  wire          wr_en,
   input  wire [AW-1:0] wr_addr,
   input  wire [DW-1:0] wr_data,
   input  wire [AW-1:0] rd_a_addr,
   output reg  [DW-1:0] rd_a_data,
   input  wire [AW-1:0] rd_b_addr,
   output reg  [DW-1:0] rd_b_data
);

   reg [DW-1:0] mem [0:DEPTH-1];
   integer      i;

   // storage, each entry resets to its own index
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (i = 0; i < DEPTH; i = i + 1)
            mem[i] <= i[DW-1:0];
      end
      else if (wr_en && (wr_addr < DEPTH))
         mem[wr_addr] <= wr_data;
   end

   // two registered read ports
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rd_a_data <= {DW{1'b0}};
         rd_b_data <= {DW{1'b0}};
      end
      else
      begin
         rd_a_data <= (rd_a_addr < DEPTH) ? mem[rd_a_addr] : {DW{1'b0}};
         rd_b_data <= (rd_b_addr < DEPTH) ? mem[rd_b_addr] : {DW{1'b0}};
      end
   end

endmodule

`default_nettype wire

// file: hdl/psm_placeholder_none.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: bench/psm_mux_properties.sv
`timescale 1ns/1ps
`default_nettype none

module psm_mux_chk #(
   parameter NPORT = 12
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic [11:0] rx_recovered_clk,
   input wire logic [1:0]  recovered_clk_out,
   input wire logic [47:0] port_macro_code,
   input wire logic [11:0] port_linked,
   input wire logic [8:0]  macro_busy,
   input wire logic        quad_lane_active,
   input wire logic        fast_lane_c_endpoint,
   input wire logic [3:0]  lp_query_port,
   input wire logic [3:0]  lp_query_value
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // one wait state, then a single-cycle answer
   apb_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer timing wrong");
   cpu_unrouted_a: assert property (port_macro_code[47:44] == 4'h0 && !port_linked[11])
      else $error("cpu port routed");
   quad_lanes_a: assert property (quad_lane_active |-> port_macro_code[31:16] == 16'h7777)
      else $error("quad ports not on lane a");
   nine_choice_a: assert property (port_macro_code[39:36] == 4'h0 || port_macro_code[39:36] == 4'h5)
      else $error("port nine bad macro");
   ten_choice_a: assert property (port_linked[10] |-> port_macro_code[43:40] inside {4'h6, 4'h9})
      else $error("port ten bad macro");
   lane_c_owner_a: assert property (port_macro_code[43:40] == 4'h9 |-> !fast_lane_c_endpoint)
      else $error("lane c shared");
   endpoint_busy_a: assert property (fast_lane_c_endpoint |-> macro_busy[8])
      else $error("endpoint lane not busy");
   gig_e_single_a: assert property (port_macro_code[39:36] == 4'h5 |->
      port_linked[9] && macro_busy[4] && port_macro_code[19:16] != 4'h5)
      else $error("gig lane e chained twice");
   lp_range_a: assert property (lp_query_port > 4'hb |=> lp_query_value == 4'h0)
      else $error("logical value beyond last port");
   rclk_src_a: assert property (|recovered_clk_out |-> $past(|rx_recovered_clk, 3))
      else $error("recovered clock without source");
   cover property (quad_lane_active);
   cover property (fast_lane_c_endpoint);
   cover property (recovered_clk_out[1]);
endmodule

bind psm_mux psm_mux_chk #(.NPORT(NPORT)) u_chk (.pclk, .presetn, .psel, .penable, .pready,
   .rx_recovered_clk, .recovered_clk_out, .port_macro_code, .port_linked, .macro_busy,
   .quad_lane_active, .fast_lane_c_endpoint, .lp_query_port, .lp_query_value);
`default_nettype wire

// file: bench/psm_lane_model.sv
`timescale 1ns/1ps
`default_nettype none

module psm_lane_model (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [11:0] port_linked,
   output var logic [11:0] rx_recovered_clk
);
   logic [7:0] div_reg;

   // linked ports give a slow clock, unlinked lines flip every cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_reg <= 8'h00;
         rx_recovered_clk <= 12'h000;
      end
      else
      begin
         div_reg <= div_reg + 8'h01;
         for (int p = 0; p < 12; p++)
            rx_recovered_clk[p] <= port_linked[p] ? div_reg[p % 4 + 1] : ~rx_recovered_clk[p];
      end
   end
endmodule
`default_nettype wire

// file: bench/port_to_serdes_mux_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "psm_map.vh"

module port_to_serdes_mux_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        quad_lane_active, fast_lane_c_endpoint;
   logic [11:0] paddr, rx_recovered_clk, port_linked;
   logic [31:0] pwdata, prdata;
   logic [1:0]  recovered_clk_out;
   logic [47:0] port_macro_code, m;
   logic [8:0]  macro_busy;
   logic [3:0]  lp_query_port, lp_query_value, cfg, c, v;
   logic [33:0] exp_q[$];
   logic [33:0] e;
   int          bad_count = 0;
   int          comparisons = 0;
   int          cycles = 0;
   int          hits;
   int          hits0;

   psm_mux u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .rx_recovered_clk, .recovered_clk_out, .port_macro_code, .port_linked,
      .macro_busy, .quad_lane_active, .fast_lane_c_endpoint, .lp_query_port, .lp_query_value);
   psm_lane_model u_lane (.pclk, .presetn, .port_linked, .rx_recovered_clk);

   task test_done;
   begin
      if (bad_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask

   task chk(input string n, input logic [47:0] s, input logic [47:0] x);
   begin
      comparisons++;
      if (s !== x)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, x, s);
      end
   end
   endtask

   // one apb transfer; the answer expected is queued for the monitor
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic r, input logic er);
   begin
      exp_q.push_back({r, er, d});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   end
   endtask

   // routing expected from the lane selects
   function automatic logic [47:0] exp_map(input logic [3:0] k);
      logic [47:0] t;
      begin
         t = 48'h090870654321;
         if (k[1])
            {t[39:36], t[19:16]} = 8'h50;
         if (k[2])
            {t[43:40], t[23:20]} = 8'h60;
         if (k[0])
            t[31:16] = 16'h7777;
         exp_map = t;
      end
   endfunction

   function automatic logic [8:0] exp_busy(input logic [3:0] k);
      logic [47:0] t;
      logic [8:0]  b;
      begin
         t = exp_map(k);
         b = {k[3], 8'h00};
         for (int i = 0; i < 12; i++)
            if (t[4*i+:4] != 4'h0)
               b[t[4*i+:4]-4'h1] = 1'b1;
         exp_busy = b;
      end
   endfunction

   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // answer monitor
   always @(posedge pclk)
      if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
      begin
         e = exp_q.pop_front();
         chk("pslverr", pslverr, e[32]);
         if (e[33])
            chk("prdata", prdata, e[31:0]);
      end

   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         bad_count++;
         test_done();
      end
   end

   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, lp_query_port, cfg} = '0;
      void'($urandom(32'h7ca4e50e));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, `PSM_OFS_ROUTE, 32'h0, 1, 0);
      apb(0, `PSM_OFS_RCLK, 32'h0, 1, 0);
      // logical table starts as identity, zero past the last port
      for (int p = 0; p < 16; p++)
      begin
         lp_query_port <= 4'(p);
         repeat (2) @(posedge pclk);
         chk("lp_reset", lp_query_value, (p < 12) ? 48'(p) : 48'h0);
      end
      // every lane select code, endpoint without port ten refused
      for (int i = 0; i < 16; i++)
      begin
         c = 4'(i);
         apb(1, `PSM_OFS_ROUTE, {28'h0, c}, 0, c[3] & ~c[2]);
         if (!(c[3] & ~c[2]))
            cfg = c;
         repeat (2) @(posedge pclk);
         m = exp_map(cfg);
         chk("macro_code", port_macro_code, m);
         chk("busy", macro_busy, exp_busy(cfg));
         chk("flags", {quad_lane_active, fast_lane_c_endpoint}, {cfg[0], cfg[3]});
         for (int i = 0; i < 12; i++)
            chk("linked", port_linked[i], m[4*i+:4] != 4'h0);
         apb(0, `PSM_OFS_ROUTE, {28'h0, cfg}, 1, 0);
         apb(0, `PSM_OFS_STATUS, {21'h0, exp_busy(cfg), cfg[3], cfg[0]}, 1, 0);
         apb(0, `PSM_OFS_MAP_LO, m[31:0], 1, 0);
         apb(0, `PSM_OFS_MAP_HI, {16'h0, m[47:32]}, 1, 0);
      end
      apb(1, `PSM_OFS_STATUS, 32'hffff, 0, 1);
      apb(1, `PSM_OFS_MAP_LO, 32'h0, 0, 1);
      apb(0, 12'h100, 32'h0, 0, 1);
      apb(0, `PSM_OFS_ROUTE, {28'h0, cfg}, 1, 0);
      // random logical values, out-of-range writes refused
      for (int p = 0; p < 12; p++)
      begin
         v = 4'($urandom_range(p, 0));
         apb(1, `PSM_OFS_LP_BASE + 12'(4 * p), {28'h0, v}, 0, 0);
         apb(1, `PSM_OFS_LP_BASE + 12'(4 * p), {28'h0, 2'b11, 2'($urandom)}, 0, 1);
         apb(0, `PSM_OFS_LP_BASE + 12'(4 * p), {28'h0, v}, 1, 0);
         lp_query_port <= 4'(p);
         repeat (2) @(posedge pclk);
         chk("lp_query", lp_query_value, v);
      end
      // each port as source of the second recovered clock output
      apb(1, `PSM_OFS_ROUTE, 32'h0, 0, 0);
      m = exp_map(4'h0);
      for (int s = 0; s < 12; s++)
      begin
         apb(1, `PSM_OFS_RCLK, 32'(32'h1010 | (s << 8) | (11 - s)), 0, 0);
         repeat (4) @(posedge pclk);
         hits = 0;
         hits0 = 0;
         repeat (80)
         begin
            @(posedge pclk);
            hits += recovered_clk_out[1];
            hits0 += recovered_clk_out[0];
         end
         chk("rclk1", hits != 0, m[4*s+:4] != 4'h0);
         chk("rclk0", hits0 != 0, m[4*(11-s)+:4] != 4'h0);
      end
      test_done();
   end
endmodule
`default_nettype wire
